// ---- logic/ensc_pkg.sv ----
// error node signal control: shared constants, register layout and carriers
// assumes one 250 MHz clock and an avalon-mm master with 32-bit data
`default_nettype none

package ensc_pkg;

  // ==========================================================
  // bus and register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FEAT = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0C;

  // ==========================================================
  // design-time options of this node
  localparam logic HAS_FAULT_IRQ = 1'b1;
  localparam logic HAS_CFI = 1'b1;
  localparam logic HAS_FI = 1'b1;
  localparam logic FAULT_SPLIT_RW = 1'b1;
  localparam logic HAS_ABORT = 1'b1;
  localparam logic HAS_ABORT_EN = 1'b1;
  localparam logic ABORT_SPLIT_RW = 1'b1;
  localparam logic [1:0] CRIT_CAP = 2'h1;
  localparam logic HAS_CE_CNT = 1'b1;
  localparam logic CNT_PAIR = 1'b1;
  localparam logic HAS_UI = 1'b1;
  localparam logic HAS_DUI = 1'b1;
  localparam int CNT_W = 8;

  // ==========================================================
  // error kinds carried with a detected error
  localparam logic [1:0] KIND_CE = 2'h1;
  localparam logic [1:0] KIND_DE = 2'h2;
  localparam logic [1:0] KIND_UE = 2'h3;

  // ==========================================================
  // register layouts, bit 0 is the last field
  typedef struct packed {
    logic dui_en;
    logic ui_en;
    logic critical_irq_enable;
    logic write_abort_enable;
    logic read_abort_enable;
    logic cfi_wr;
    logic cfi_rd;
    logic fi_wr;
    logic fi_rd;
  } ensc_ctrl_t;

  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RST = 9'h000;

  typedef struct packed {
    logic uncontained;
    logic critical_flag;
    logic abort_reported_flag;
    logic wr_seen;
    logic rd_seen;
    logic of_other;
    logic of_repeat;
    logic ue;
    logic de;
    logic ce;
    logic v;
  } ensc_stat_t;

  localparam int STAT_W = 11;
  localparam logic [10:0] STAT_RST = 11'h000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic is_write;
    logic same_loc;
    logic critical;
    logic wants_resp;
  } ensc_err_t;

  typedef enum logic {ENSC_BUS_IDLE, ENSC_BUS_ACK} ensc_bus_t;

  typedef struct packed {
    ensc_bus_t bus;
    logic [DATA_W-1:0] rdata;
    ensc_ctrl_t ctrl;
    ensc_stat_t stat;
    logic [CNT_W-1:0] cnt_rpt;
    logic [CNT_W-1:0] cnt_oth;
    logic fault_irq;
    logic recov_irq;
    logic crit_irq;
    logic abort;
    logic abort_wr;
  } ensc_state_t;

endpackage : ensc_pkg

`default_nettype wire

// ---- logic/ensc_node.sv ----
// error node signal control: status, enables, counters and the three
// level interrupts plus the in-band abort pulse of one error record
// assumes err_i comes from node logic on clk_i, one error per cycle
`default_nettype none

// Functional notes
// - corrected-only enable gates the fault interrupt for corrected events only
// - with corrected-only enable, general enable gates deferred and uncorrected
// - without corrected-only enable, general enable gates every error kind
// - fault interrupt without general enable is always enabled
// - no fault interrupt means no fault enable bits at all
// - with a counter, a corrected event is the counter overflowing
// - software setting overflow flag need not count as an event
// - without a counter every corrected error is an event
// - fault enables may be split into read and write bits
// - fault interrupt raised on every deferred or uncorrected error whose read or write fault enable is set, even a discarded syndrome
// - abort enable gates in-band abort for uncorrected errors
// - no abort enable means aborts always on; no aborts means no control
// - abort enable may be split into read and write bits
// - signalling an abort sets the abort-reported flag
// - critical interrupt exists when capability field is nonzero
// - critical interrupt implies the recovery interrupt exists
// - critical interrupt enabled only while its enable bit is one
// - critical condition sets the critical flag whether enabled or not
// - disabled critical interrupt records the condition as uncontained
// - critical flag set alongside the normal syndrome handling
// - fault interrupt while corrected enable and counter overflow set
// - repeat and other counters, either overflow raises fault interrupt
// - recovery interrupt held while enabled and valid and uncorrected set
// - without uncorrected enable, recovery on uncorrected is always on
module ensc_node (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ensc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ensc_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [ensc_pkg::DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire ensc_pkg::ensc_err_t err_i,
  output logic fault_irq_o,
  output logic recovery_irq_o,
  output logic critical_irq_o,
  output logic abort_o,
  output logic abort_is_write_o
);

  // ==========================================================
  // implemented options
  localparam logic CRIT_IMPL = (ensc_pkg::CRIT_CAP != 2'h0);
  localparam logic RECOV_IMPL = 1'b1;
  localparam logic CNT_PAIR_B = ensc_pkg::CNT_PAIR;
  localparam logic FI_IMPL = ensc_pkg::HAS_FAULT_IRQ & ensc_pkg::HAS_FI;
  localparam logic CFI_IMPL = FI_IMPL & ensc_pkg::HAS_CFI;
  localparam logic AB_EN_IMPL = ensc_pkg::HAS_ABORT & ensc_pkg::HAS_ABORT_EN;
  localparam logic [8:0] CTRL_MASK = {
    ensc_pkg::HAS_DUI & RECOV_IMPL,
    ensc_pkg::HAS_UI & RECOV_IMPL,
    CRIT_IMPL,
    AB_EN_IMPL & ensc_pkg::ABORT_SPLIT_RW,
    AB_EN_IMPL,
    CFI_IMPL & ensc_pkg::FAULT_SPLIT_RW,
    CFI_IMPL,
    FI_IMPL & ensc_pkg::FAULT_SPLIT_RW,
    FI_IMPL
  };

  ensc_pkg::ensc_state_t st_ff;
  ensc_pkg::ensc_state_t nxt_st;

  // ==========================================================
  // effective enables
  logic fi_rd_en;
  logic fi_wr_en;
  logic cfi_rd_en;
  logic cfi_wr_en;
  logic ab_rd_en;
  logic ab_wr_en;
  logic ui_en;
  logic dui_en;
  logic ci_en;

  always_comb begin
    if (!ensc_pkg::HAS_FAULT_IRQ) begin
      fi_rd_en = 1'b0;
      fi_wr_en = 1'b0;
    end else if (FI_IMPL) begin
      fi_rd_en = st_ff.ctrl.fi_rd;
      fi_wr_en = ensc_pkg::FAULT_SPLIT_RW ? st_ff.ctrl.fi_wr : st_ff.ctrl.fi_rd;
    end else begin
      fi_rd_en = 1'b1;
      fi_wr_en = 1'b1;
    end
    if (CFI_IMPL) begin
      cfi_rd_en = st_ff.ctrl.cfi_rd;
      cfi_wr_en = ensc_pkg::FAULT_SPLIT_RW ? st_ff.ctrl.cfi_wr : st_ff.ctrl.cfi_rd;
    end else begin
      cfi_rd_en = fi_rd_en;
      cfi_wr_en = fi_wr_en;
    end
    if (!ensc_pkg::HAS_ABORT) begin
      ab_rd_en = 1'b0;
      ab_wr_en = 1'b0;
    end else if (AB_EN_IMPL) begin
      ab_rd_en = st_ff.ctrl.read_abort_enable;
      ab_wr_en = ensc_pkg::ABORT_SPLIT_RW ? st_ff.ctrl.write_abort_enable
                                          : st_ff.ctrl.read_abort_enable;
    end else begin
      ab_rd_en = 1'b1;
      ab_wr_en = 1'b1;
    end
    ui_en = ensc_pkg::HAS_UI ? st_ff.ctrl.ui_en : 1'b1;
    dui_en = ensc_pkg::HAS_DUI & st_ff.ctrl.dui_en;
    ci_en = CRIT_IMPL & st_ff.ctrl.critical_irq_enable;
  end

  // ==========================================================
  // classification of the incoming error
  logic crit_det;
  logic crit_uc;
  logic ce_det;
  logic de_det;
  logic ue_det;
  logic use_rpt;

  always_comb begin
    crit_det = err_i.valid & err_i.critical & CRIT_IMPL;
    crit_uc = crit_det & ~ci_en;
    ce_det = err_i.valid & (err_i.kind == ensc_pkg::KIND_CE) & ~crit_uc;
    de_det = err_i.valid & (err_i.kind == ensc_pkg::KIND_DE) & ~crit_uc;
    ue_det = err_i.valid & ((err_i.kind == ensc_pkg::KIND_UE) | crit_uc);
    use_rpt = err_i.same_loc | ~ensc_pkg::CNT_PAIR;
  end

  // ==========================================================
  // bus decode
  logic acc;
  logic wr_go;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_cnt;
  logic [ensc_pkg::DATA_W-1:0] wmask;
  logic [ensc_pkg::DATA_W-1:0] wdata;
  logic [ensc_pkg::DATA_W-1:0] rd_val;

  always_comb begin
    acc = avs_read_i | avs_write_i;
    wr_go = avs_write_i & (st_ff.bus == ensc_pkg::ENSC_BUS_ACK);
    wr_ctrl = wr_go & (avs_address_i == ensc_pkg::OFS_CTRL);
    wr_stat = wr_go & (avs_address_i == ensc_pkg::OFS_STAT);
    wr_cnt = wr_go & (avs_address_i == ensc_pkg::OFS_CNT);
    wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
             {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    wdata = avs_writedata_i & wmask;
    case (avs_address_i)
      ensc_pkg::OFS_CTRL: rd_val = {23'h000000, st_ff.ctrl};
      ensc_pkg::OFS_FEAT: rd_val = {16'h0000, CNT_PAIR_B, ensc_pkg::HAS_CE_CNT,
                                    ensc_pkg::HAS_DUI, ensc_pkg::HAS_UI,
                                    ensc_pkg::ABORT_SPLIT_RW, ensc_pkg::HAS_ABORT_EN,
                                    ensc_pkg::HAS_ABORT, ensc_pkg::FAULT_SPLIT_RW,
                                    ensc_pkg::HAS_CFI, ensc_pkg::HAS_FI,
                                    ensc_pkg::HAS_FAULT_IRQ, 3'h0, ensc_pkg::CRIT_CAP};
      ensc_pkg::OFS_STAT: rd_val = {21'h000000, st_ff.stat};
      ensc_pkg::OFS_CNT: rd_val = {16'h0000, st_ff.cnt_oth, st_ff.cnt_rpt};
      default: rd_val = 32'h00000000;
    endcase
  end

  // ==========================================================
  // next state
  logic [ensc_pkg::CNT_W:0] rpt_sum;
  logic [ensc_pkg::CNT_W:0] oth_sum;
  logic ab_fire;
  logic ce_pend;
  logic fault_lvl;
  logic recov_lvl;
  logic crit_lvl;

  always_comb begin
    nxt_st = st_ff;
    rpt_sum = {1'b0, st_ff.cnt_rpt} + 9'h001;
    oth_sum = {1'b0, st_ff.cnt_oth} + 9'h001;
    ab_fire = ensc_pkg::HAS_ABORT & ue_det & err_i.wants_resp
              & (err_i.is_write ? ab_wr_en : ab_rd_en);

    // bus handshake: one idle cycle, then one acknowledge cycle
    case (st_ff.bus)
      ensc_pkg::ENSC_BUS_IDLE: begin
        if (acc) begin
          nxt_st.bus = ensc_pkg::ENSC_BUS_ACK;
          nxt_st.rdata = avs_read_i ? rd_val : 32'h00000000;
        end
      end
      ensc_pkg::ENSC_BUS_ACK: begin
        nxt_st.bus = ensc_pkg::ENSC_BUS_IDLE;
      end
      default: begin
        nxt_st.bus = ensc_pkg::ENSC_BUS_IDLE;
      end
    endcase

    // software writes first, hardware sets afterwards so a set wins
    if (wr_ctrl) begin
      nxt_st.ctrl = ensc_pkg::ensc_ctrl_t'(wdata[8:0] & CTRL_MASK);
    end
    if (wr_stat) begin
      nxt_st.stat = ensc_pkg::ensc_stat_t'(st_ff.stat & ~wdata[10:0]);
    end
    if (wr_cnt) begin
      nxt_st.cnt_rpt = wdata[7:0];
      nxt_st.cnt_oth = wdata[15:8];
    end

    // recording; flags set even when the syndrome itself is dropped
    if (err_i.valid) begin
      nxt_st.stat.v = 1'b1;
      nxt_st.stat.rd_seen = nxt_st.stat.rd_seen | ~err_i.is_write;
      nxt_st.stat.wr_seen = nxt_st.stat.wr_seen | err_i.is_write;
    end
    if (ce_det) begin
      nxt_st.stat.ce = 1'b1;
    end
    if (ce_det && ensc_pkg::HAS_CE_CNT && !wr_cnt) begin
      if (use_rpt) begin
        nxt_st.cnt_rpt = rpt_sum[ensc_pkg::CNT_W-1:0];
        if (rpt_sum[ensc_pkg::CNT_W]) begin
          nxt_st.stat.of_repeat = 1'b1;
        end
      end else begin
        nxt_st.cnt_oth = oth_sum[ensc_pkg::CNT_W-1:0];
        if (oth_sum[ensc_pkg::CNT_W]) begin
          nxt_st.stat.of_other = 1'b1;
        end
      end
    end
    if (de_det) begin
      nxt_st.stat.de = 1'b1;
    end
    if (ue_det) begin
      nxt_st.stat.ue = 1'b1;
    end
    if (crit_uc) begin
      nxt_st.stat.uncontained = 1'b1;
    end
    if (crit_det) begin
      nxt_st.stat.critical_flag = 1'b1;
    end
    if (ab_fire) begin
      nxt_st.stat.abort_reported_flag = 1'b1;
    end
    nxt_st.abort = ab_fire;
    nxt_st.abort_wr = ab_fire & err_i.is_write;

    // level interrupts from the registered status and enables
    nxt_st.fault_irq = fault_lvl;
    nxt_st.recov_irq = recov_lvl;
    nxt_st.crit_irq = crit_lvl;
  end

  // ==========================================================
  // interrupt levels
  always_comb begin
    if (ensc_pkg::HAS_CE_CNT) begin
      ce_pend = st_ff.stat.of_repeat | st_ff.stat.of_other;
    end else begin
      ce_pend = st_ff.stat.ce;
    end
    fault_lvl = ensc_pkg::HAS_FAULT_IRQ & st_ff.stat.v & (
        ((st_ff.stat.de | st_ff.stat.ue)
         & ((st_ff.stat.rd_seen & fi_rd_en) | (st_ff.stat.wr_seen & fi_wr_en)))
      | (ce_pend
         & ((st_ff.stat.rd_seen & cfi_rd_en) | (st_ff.stat.wr_seen & cfi_wr_en))));
    recov_lvl = RECOV_IMPL & st_ff.stat.v & (
        (ui_en & st_ff.stat.ue)
      | (dui_en & st_ff.stat.de));
    crit_lvl = ci_en & st_ff.stat.v & st_ff.stat.critical_flag;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_ff.bus <= ensc_pkg::ENSC_BUS_IDLE;
      st_ff.rdata <= 32'h00000000;
      st_ff.ctrl <= ensc_pkg::ensc_ctrl_t'(ensc_pkg::CTRL_RST);
      st_ff.stat <= ensc_pkg::ensc_stat_t'(ensc_pkg::STAT_RST);
      st_ff.cnt_rpt <= 8'h00;
      st_ff.cnt_oth <= 8'h00;
      st_ff.fault_irq <= 1'b0;
      st_ff.recov_irq <= 1'b0;
      st_ff.crit_irq <= 1'b0;
      st_ff.abort <= 1'b0;
      st_ff.abort_wr <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign avs_readdata_o = st_ff.rdata;
  assign avs_waitrequest_o = ~(st_ff.bus == ensc_pkg::ENSC_BUS_ACK);
  assign fault_irq_o = st_ff.fault_irq;
  assign recovery_irq_o = st_ff.recov_irq;
  assign critical_irq_o = st_ff.crit_irq;
  assign abort_o = st_ff.abort;
  assign abort_is_write_o = st_ff.abort_wr;

endmodule // ensc_node

`default_nettype wire

// ---- sim/ensc_node_monitor.sv ----
// checker for the error node: abort and interrupt relations at the ports
// assumes one clock, reset active low, ctrl tracked from accepted bus writes
`default_nettype none

module ensc_node_monitor (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [ensc_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ensc_pkg::DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [ensc_pkg::DATA_W-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire ensc_pkg::ensc_err_t err_i,
  input wire logic fault_irq_o,
  input wire logic recovery_irq_o,
  input wire logic critical_irq_o,
  input wire logic abort_o,
  input wire logic abort_is_write_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================
  // shadow of the control word
  logic [8:0] ctrl_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= 9'h000;
    end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == ensc_pkg::OFS_CTRL) begin
      ctrl_ff <= {avs_writedata_i[8] & avs_byteenable_i[1],
                  avs_writedata_i[7:0] & {8{avs_byteenable_i[0]}}};
    end
  end
  wire logic crit_in = err_i.valid && err_i.critical;
  wire logic as_ue = (err_i.valid && err_i.kind == ensc_pkg::KIND_UE) || (crit_in && !ctrl_ff[6]);
  wire logic ab_en = err_i.is_write ? ctrl_ff[5] : ctrl_ff[4];
  wire logic fi_en = err_i.is_write ? ctrl_ff[1] : ctrl_ff[0];
  wire logic abort_due = err_i.valid && err_i.wants_resp && as_ue && ab_en;
  wire logic fault_any = |ctrl_ff[3:0];
  wire logic recov_any = ctrl_ff[7] | ctrl_ff[8];
  wire logic crit_en = ctrl_ff[6];
  wire logic err_wr = err_i.is_write;

  // ==========================================================
  // properties
  sequence s_abort_req;
    abort_due;
  endsequence
  sequence s_abort_seen;
    abort_o && abort_is_write_o == $past(err_wr);
  endsequence
  property p_abort_fires;
    s_abort_req |=> s_abort_seen;
  endproperty
  a_abort_fires: assert property (p_abort_fires) else $error("abort missing");
  property p_abort_cause;
    abort_o |-> $past(abort_due);
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("abort without cause");
  property p_abort_dir;
    abort_o |-> abort_is_write_o == $past(err_wr);
  endproperty
  a_abort_dir: assert property (p_abort_dir) else $error("abort direction wrong");
  property p_fault_gate;
    fault_irq_o |-> $past(fault_any);
  endproperty
  a_fault_gate: assert property (p_fault_gate) else $error("fault irq not enabled");
  property p_fault_raise;
    err_i.valid && err_i.kind != ensc_pkg::KIND_CE && fi_en |-> ##[1:3] fault_irq_o;
  endproperty
  a_fault_raise: assert property (p_fault_raise) else $error("fault irq missing");
  property p_recov_raise;
    as_ue && ctrl_ff[7] |-> ##[1:3] recovery_irq_o;
  endproperty
  a_recov_raise: assert property (p_recov_raise) else $error("recovery irq missing");
  property p_recov_gate;
    recovery_irq_o |-> $past(recov_any);
  endproperty
  a_recov_gate: assert property (p_recov_gate) else $error("recovery irq not enabled");
  property p_crit_raise;
    crit_in && crit_en |-> ##[1:3] critical_irq_o;
  endproperty
  a_crit_raise: assert property (p_crit_raise) else $error("critical irq missing");
  property p_crit_gate;
    critical_irq_o |-> $past(crit_en);
  endproperty
  a_crit_gate: assert property (p_crit_gate) else $error("critical irq not enabled");
endmodule // ensc_node_monitor

bind ensc_node ensc_node_monitor u_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .err_i(err_i),
  .fault_irq_o(fault_irq_o), .recovery_irq_o(recovery_irq_o), .critical_irq_o(critical_irq_o),
  .abort_o(abort_o), .abort_is_write_o(abort_is_write_o));

`default_nettype wire

// ---- sim/ensc_host_model.sv ----
// requester side model: takes in-band aborts, keeps count and direction
// assumes abort pulses are one cycle per error
`default_nettype none

module ensc_host_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic abort_i,
  input wire logic abort_is_write_i,
  output logic [7:0] n_abort_o,
  output logic last_write_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      n_abort_o <= 8'h00;
      last_write_o <= 1'h0;
    end else if (abort_i) begin
      n_abort_o <= n_abort_o + 8'h01;
      last_write_o <= abort_is_write_i;
    end
  end
endmodule // ensc_host_model

`default_nettype wire

// ---- sim/tb_error_node_signal_control.sv ----
// testbench for the error node: bus tasks, error injection, level checks
// assumes the node, its package and the host model are compiled first
`default_nettype none

module tb_error_node_signal_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FEAT_EXP = {16'h0000, ensc_pkg::CNT_PAIR, ensc_pkg::HAS_CE_CNT,
    ensc_pkg::HAS_DUI, ensc_pkg::HAS_UI, ensc_pkg::ABORT_SPLIT_RW, ensc_pkg::HAS_ABORT_EN,
    ensc_pkg::HAS_ABORT, ensc_pkg::FAULT_SPLIT_RW, ensc_pkg::HAS_CFI, ensc_pkg::HAS_FI,
    ensc_pkg::HAS_FAULT_IRQ, 3'h0, ensc_pkg::CRIT_CAP};
  logic clk_i;
  logic rst_b_i;
  logic [7:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  ensc_pkg::ensc_err_t err_i;
  logic fault_o, recov_o, crit_o, abort_o, abort_wr_o, last_wr;
  logic [7:0] n_abort;
  logic [31:0] rdat;
  int n_mismatch;
  int n_checks;

  ensc_node DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .err_i(err_i), .fault_irq_o(fault_o),
    .recovery_irq_o(recov_o), .critical_irq_o(crit_o), .abort_o(abort_o),
    .abort_is_write_o(abort_wr_o));
  ensc_host_model u_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .abort_i(abort_o),
    .abort_is_write_i(abort_wr_o), .n_abort_o(n_abort), .last_write_o(last_wr));

  initial begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end

  // ==========================================================
  // tasks
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'h0);
    rdat = avs_readdata_o;
    avs_read_i <= 1'h0;
    avs_write_i <= 1'h0;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(nm, rdat, exp);
  endtask
  task automatic inj(input logic [1:0] k, input logic w, s, c, r);
    @(posedge clk_i);
    err_i <= {1'h1, k, w, s, c, r};
    @(posedge clk_i);
    err_i <= '0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic clr();
    bus(1'h1, ensc_pkg::OFS_STAT, 32'h7FF);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk_i);
    n_mismatch++;
    $display("watchdog expired");
    end_of_test();
  end

  // ==========================================================
  // tests
  initial begin
    rst_b_i = 1'h0;
    avs_address_i = 8'h00;
    avs_read_i = 1'h0;
    avs_write_i = 1'h0;
    avs_writedata_i = 32'h0;
    err_i = '0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'h1;
    rc("ctrl", ensc_pkg::OFS_CTRL, 32'h0);
    bus(1'h1, ensc_pkg::OFS_FEAT, 32'h0);
    rc("feat", ensc_pkg::OFS_FEAT, FEAT_EXP);
    rc("stat", ensc_pkg::OFS_STAT, 32'h0);
    rc("unmapped", 8'h10, 32'h0);
    $display("test registers done");
    inj(ensc_pkg::KIND_UE, 1'h0, 1'h0, 1'h0, 1'h1);
    chk("fault off", fault_o, 32'h0);
    chk("recov off", recov_o, 32'h0);
    chk("no abort", n_abort, 32'h0);
    rc("stat ue", ensc_pkg::OFS_STAT, 32'h49);
    bus(1'h1, ensc_pkg::OFS_CTRL, 32'h81);
    repeat (3) @(posedge clk_i);
    chk("fault on", fault_o, 32'h1);
    chk("recov on", recov_o, 32'h1);
    clr();
    chk("fault clr", fault_o, 32'h0);
    $display("test enables done");
    bus(1'h1, ensc_pkg::OFS_CTRL, 32'h11);
    inj(ensc_pkg::KIND_UE, 1'h1, 1'h0, 1'h0, 1'h1);
    chk("wr abort off", n_abort, 32'h0);
    chk("wr fault off", fault_o, 32'h0);
    inj(ensc_pkg::KIND_UE, 1'h0, 1'h0, 1'h0, 1'h1);
    chk("rd abort", n_abort, 32'h1);
    chk("rd abort dir", last_wr, 32'h0);
    chk("rd fault", fault_o, 32'h1);
    rc("stat abort", ensc_pkg::OFS_STAT, 32'h1C9);
    clr();
    bus(1'h1, ensc_pkg::OFS_CTRL, 32'h22);
    inj(ensc_pkg::KIND_DE, 1'h1, 1'h0, 1'h0, 1'h1);
    chk("de no abort", n_abort, 32'h1);
    inj(ensc_pkg::KIND_UE, 1'h1, 1'h0, 1'h0, 1'h1);
    chk("wr abort", n_abort, 32'h2);
    chk("wr abort dir", last_wr, 32'h1);
    clr();
    $display("test aborts done");
    bus(1'h1, ensc_pkg::OFS_CTRL, 32'h04);
    bus(1'h1, ensc_pkg::OFS_CNT, 32'hFFFE);
    inj(ensc_pkg::KIND_CE, 1'h0, 1'h1, 1'h0, 1'h0);
    chk("ce no event", fault_o, 32'h0);
    rc("count", ensc_pkg::OFS_CNT, 32'hFFFF);
    inj(ensc_pkg::KIND_CE, 1'h0, 1'h1, 1'h0, 1'h0);
    chk("repeat overflow", fault_o, 32'h1);
    rc("count wrap", ensc_pkg::OFS_CNT, 32'hFF00);
    clr();
    chk("overflow clr", fault_o, 32'h0);
    inj(ensc_pkg::KIND_CE, 1'h0, 1'h0, 1'h0, 1'h0);
    chk("other overflow", fault_o, 32'h1);
    rc("stat other", ensc_pkg::OFS_STAT, 32'h63);
    clr();
    $display("test counters done");
    bus(1'h1, ensc_pkg::OFS_CTRL, 32'h40);
    inj(ensc_pkg::KIND_CE, 1'h0, 1'h0, 1'h1, 1'h0);
    chk("crit on", crit_o, 32'h1);
    rc("stat crit", ensc_pkg::OFS_STAT, 32'h243);
    clr();
    chk("crit clr", crit_o, 32'h0);
    bus(1'h1, ensc_pkg::OFS_CTRL, 32'h80);
    inj(ensc_pkg::KIND_CE, 1'h0, 1'h0, 1'h1, 1'h0);
    chk("crit off", crit_o, 32'h0);
    chk("uncontained recov", recov_o, 32'h1);
    rc("stat uncontained", ensc_pkg::OFS_STAT, 32'h649);
    $display("test critical done");
    clr();
    bus(1'h1, ensc_pkg::OFS_CTRL, 32'h100);
    inj(ensc_pkg::KIND_DE, 1'h0, 1'h0, 1'h0, 1'h0);
    chk("de recov", recov_o, 32'h1);
    chk("de fault off", fault_o, 32'h0);
    rc("stat de", ensc_pkg::OFS_STAT, 32'h45);
    $display("test deferred done");
    end_of_test();
  end
endmodule // tb_error_node_signal_control

`default_nettype wire
